// file: core/pcm_pkg.sv
package pcm_pkg;

  // Controller clock rate
  localparam longint unsigned CLK_FREQ_HZ      = 64'd100_000_000;
  localparam longint unsigned CYC_PER_MS       = CLK_FREQ_HZ / 64'd1000;

  // Restart pulse high-time limits, in milliseconds
  localparam longint unsigned RST_MIN_SHORT_MS = 64'd100;
  localparam longint unsigned RST_MIN_LONG_MS  = 64'd350;
  localparam longint unsigned RST_MAX_MS       = 64'd30_000;

  // Same limits in clock cycles (exact at 100 MHz)
  localparam longint unsigned RST_MIN_SHORT_CYC = RST_MIN_SHORT_MS * CYC_PER_MS;
  localparam longint unsigned RST_MIN_LONG_CYC  = RST_MIN_LONG_MS * CYC_PER_MS;
  localparam longint unsigned RST_MAX_CYC       = RST_MAX_MS * CYC_PER_MS;

  // Restart pulse counter width
  localparam int unsigned CNT_W = 32;

  // Positions of the filtered pin inputs
  localparam int unsigned PIN_N   = 5;
  localparam int unsigned IDX_UDP = 0;
  localparam int unsigned IDX_LDP = 1;
  localparam int unsigned IDX_RD  = 2;
  localparam int unsigned IDX_RST = 3;
  localparam int unsigned IDX_REL = 4;

  // Lower contact rising edges per cycle counter
  localparam logic [1:0] LDP_CNT_ZERO = 2'h0;
  localparam logic [1:0] LDP_CNT_ONE  = 2'h1;
  localparam logic [1:0] LDP_CNT_MAX  = 2'h2;
  localparam logic [1:0] LDP_CNT_STEP = 2'h1;

endpackage : pcm_pkg

// file: core/pcm_sync.sv
`timescale 1ns/100ps
module pcm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_q
);

  // Three stages plus the accepted level
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pcm_sync_s;

  pcm_sync_s st_reg;
  pcm_sync_s st_next;

  // Shift and accept a level once stages two and three agree
  always_comb
  begin
    st_next = st_reg;
    if (clk_en)
    begin
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // Stage one is never looked at here, only copied on
      st_next.q  = ((st_reg.s2 ~^ st_reg.s3) & st_reg.s2) |
                   ((st_reg.s2 ^ st_reg.s3) & st_reg.q);
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign pin_q = st_reg.q;

endmodule : pcm_sync

// file: core/pcm_monitor.sv
// Operation
// RULE_01 - Error flag mirrors any latched error
// RULE_02 - Restart pulse high time within limits
// RULE_03 - Restart disabled: only reset clears errors
// RULE_04 - Lower contact pulses once per cycle
// RULE_05 - Lower contact high at start: no upstroke
// RULE_06 - Second lower edge does not re-set upstroke
// RULE_07 - No lower pulse keeps upstroke low
// RULE_08 - Lower high at monitor start waits top fall
// RULE_09 - Ramp-down leave needs drive start seen
// RULE_10 - Release input low suspends checking
// RULE_11 - Release input edges drop or restore outputs
// RULE_12 - Release high unless error; error drops it
// RULE_13 - Top follows upper contact low, gated
// RULE_14 - Upstroke set by lower rise, cleared early
// RULE_15 - Restart required holds; blocks release
// RULE_16 - Any bad contact order latches contact error
// RULE_17 - Drive start comes from internal logic
// RULE_18 - Ramp-down and upper contact overlap
// RULE_19 - Lower rise only while upper contact high
// RULE_20 - Lower contact low when upper rises
// RULE_21 - Sample per cycle, edges versus last
// RULE_22 - Valid restart clears all errors together
`timescale 1ns/100ps
module pcm_monitor #(
  parameter logic [pcm_pkg::CNT_W-1:0] RST_MIN_SHORT_CYC =
    pcm_pkg::CNT_W'(pcm_pkg::RST_MIN_SHORT_CYC),
  parameter logic [pcm_pkg::CNT_W-1:0] RST_MIN_LONG_CYC  =
    pcm_pkg::CNT_W'(pcm_pkg::RST_MIN_LONG_CYC),
  parameter logic [pcm_pkg::CNT_W-1:0] RST_MAX_CYC       = pcm_pkg::CNT_W'(pcm_pkg::RST_MAX_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic upper_dead_point_contact,
  input  wire logic lower_dead_point_contact,
  input  wire logic ramp_down_contact,
  input  wire logic restart_in,
  input  wire logic release_in,
  input  wire logic drive_start,
  input  wire logic cfg_restart_enable,
  input  wire logic cfg_lower_multi,
  input  wire logic cfg_restart_long,
  input  wire logic cfg_error_flag_enable,
  input  wire logic cfg_ramp_down_enable,
  output logic      release_out,
  output logic      top_out,
  output logic      upstroke_out,
  output logic      restart_required,
  output logic      contact_error,
  output logic      ramp_down_error,
  output logic      error_flag
);

  // Whole block state
  typedef struct packed {
    logic                      init;       // Monitoring must (re)start
    logic                      udp_q;      // Last upper contact sample
    logic                      ldp_q;      // Last lower contact sample
    logic                      rd_q;       // Last ramp-down sample
    logic                      rst_q;      // Last restart sample
    logic                      start_q;    // Last drive start sample
    logic                      armed;      // Lower edges accepted
    logic [1:0]                ldp_cnt;    // Lower rises this cycle
    logic                      up_done;    // Upstroke already given
    logic                      up_phase;   // Upstroke phase running
    logic                      start_seen; // Drive start rose after top
    logic                      rd_fell;    // Ramp-down left this cycle
    logic [pcm_pkg::CNT_W-1:0] rst_cnt;    // Restart high time
    logic                      c_err;
    logic                      r_err;
    logic                      rst_req;
    logic                      rel_o;
    logic                      top_o;
    logic                      up_o;
    logic                      flag_o;
  } pcm_mon_s;

  pcm_mon_s                  st_reg;
  pcm_mon_s                  st_next;
  logic [pcm_pkg::PIN_N-1:0] pin_raw;   // Pins before filtering
  logic [pcm_pkg::PIN_N-1:0] pin_q;     // Filtered pin levels

  assign pin_raw[pcm_pkg::IDX_UDP] = upper_dead_point_contact;
  assign pin_raw[pcm_pkg::IDX_LDP] = lower_dead_point_contact;
  assign pin_raw[pcm_pkg::IDX_RD]  = ramp_down_contact;
  assign pin_raw[pcm_pkg::IDX_RST] = restart_in;
  assign pin_raw[pcm_pkg::IDX_REL] = release_in;

  // Pin filter; drive start is internal and bypasses it
  pcm_sync #(
    .W (pcm_pkg::PIN_N)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .pin_in  (pin_raw),
    .pin_q   (pin_q)
  );

  // One logic cycle of evaluation per enabled clock
  always_comb
  begin
    logic                      udp;
    logic                      ldp;
    logic                      rd;
    logic                      rst;
    logic                      rel;
    logic                      udp_rise;
    logic                      udp_fall;
    logic                      ldp_rise;
    logic                      ldp_fall;
    logic                      rd_fall;
    logic                      start_rise;
    logic                      rst_fall;
    logic                      rst_ok;
    logic                      c_det;
    logic                      r_det;
    logic [pcm_pkg::CNT_W-1:0] min_cyc;
    udp        = pin_q[pcm_pkg::IDX_UDP];
    ldp        = pin_q[pcm_pkg::IDX_LDP];
    rd         = pin_q[pcm_pkg::IDX_RD];
    rst        = pin_q[pcm_pkg::IDX_RST];
    rel        = pin_q[pcm_pkg::IDX_REL];
    // RULE_21 edges versus last
    udp_rise   = udp & ~st_reg.udp_q;
    udp_fall   = ~udp & st_reg.udp_q;
    ldp_rise   = ldp & ~st_reg.ldp_q;
    ldp_fall   = ~ldp & st_reg.ldp_q;
    rd_fall    = ~rd & st_reg.rd_q;
    start_rise = drive_start & ~st_reg.start_q;
    rst_fall   = ~rst & st_reg.rst_q;
    rst_ok     = 1'b0;
    c_det      = 1'b0;
    r_det      = 1'b0;
    min_cyc    = cfg_restart_long ? RST_MIN_LONG_CYC : RST_MIN_SHORT_CYC;
    st_next    = st_reg;
    if (clk_en)
    begin
      // RULE_21 cycle-based pulse timer
      if (rst)
      begin
        // Saturate just past the maximum so overlong pulses stay invalid
        if (st_reg.rst_cnt <= RST_MAX_CYC)
          st_next.rst_cnt = st_reg.rst_cnt + pcm_pkg::CNT_W'(1);
      end
      else
      begin
        // RULE_02 window check at fall
        // RULE_03 disabled input never validates
        rst_ok = rst_fall & cfg_restart_enable &
                 (st_reg.rst_cnt >= min_cyc) & (st_reg.rst_cnt <= RST_MAX_CYC);
        st_next.rst_cnt = '0;
      end
      if (rst_ok && st_reg.rst_req)
      begin
        // RULE_22 clear errors together
        st_next.c_err   = 1'b0;
        st_next.r_err   = 1'b0;
        st_next.rst_req = 1'b0;
        st_next.init    = 1'b1;
      end
      else if (!rel)
      begin
        // RULE_10 suspend checking, errors kept
        st_next.init     = 1'b1;
        st_next.up_phase = 1'b0;
      end
      else if (st_reg.rst_req)
      begin
        // Latched error: nothing moves until a valid restart
        st_next.up_phase = 1'b0;
      end
      else if (st_reg.init)
      begin
        // RULE_11 fresh start from current contacts
        // RULE_05 lower high blocks first upstroke
        st_next.init       = 1'b0;
        st_next.armed      = ~ldp;
        st_next.ldp_cnt    = pcm_pkg::LDP_CNT_ZERO;
        st_next.up_done    = 1'b0;
        st_next.up_phase   = 1'b0;
        st_next.start_seen = 1'b0;
        st_next.rd_fell    = 1'b0;
      end
      else
      begin
        // RULE_20 lower must be low at upper rise
        if (udp_rise && ldp)
          c_det = 1'b1;
        // RULE_19 lower rise only while upper high
        if (ldp_rise && !udp)
          c_det = 1'b1;
        // RULE_18 one of the two always high
        if (cfg_ramp_down_enable && !udp && !rd)
          c_det = 1'b1;
        if (ldp_rise && udp)
        begin
          // RULE_08 ignored until top falls
          if (st_reg.armed)
          begin
            if (st_reg.ldp_cnt == pcm_pkg::LDP_CNT_MAX)
              c_det = 1'b1;
            else
              st_next.ldp_cnt = st_reg.ldp_cnt + pcm_pkg::LDP_CNT_STEP;
            // Single-signal mode allows exactly one rise
            if (!cfg_lower_multi && st_reg.ldp_cnt != pcm_pkg::LDP_CNT_ZERO)
              c_det = 1'b1;
            // Single-signal with ramp-down: rise only after ramp-down left
            if (!cfg_lower_multi && cfg_ramp_down_enable && !st_reg.rd_fell)
              c_det = 1'b1;
            // RULE_06 only first rise sets
            // RULE_14 upstroke set on rise
            if (!st_reg.up_done)
            begin
              st_next.up_phase = 1'b1;
              st_next.up_done  = 1'b1;
            end
          end
        end
        // RULE_14 cleared by first fall
        if (ldp_fall)
          st_next.up_phase = 1'b0;
        if (udp_fall)
        begin
          st_next.up_phase   = 1'b0;
          // Top rises now; drive start must be seen afresh
          st_next.start_seen = 1'b0;
          // RULE_04 exactly one lower rise between upper pulses
          if (st_reg.armed && !cfg_lower_multi && st_next.ldp_cnt != pcm_pkg::LDP_CNT_ONE)
            c_det = 1'b1;
        end
        if (udp_rise)
        begin
          // RULE_08 top fell, lower edges accepted again
          // RULE_07 empty cycle leaves upstroke low
          st_next.armed   = 1'b1;
          st_next.ldp_cnt = pcm_pkg::LDP_CNT_ZERO;
          st_next.up_done = 1'b0;
          st_next.rd_fell = 1'b0;
        end
        if (start_rise && st_reg.top_o)
          st_next.start_seen = 1'b1;
        if (cfg_ramp_down_enable && rd_fall)
        begin
          // RULE_09 drive start check at leave
          if (!(st_next.start_seen || drive_start))
            r_det = 1'b1;
          // Lower contact must be low when ramp-down is left
          if (ldp)
            c_det = 1'b1;
          st_next.rd_fell    = 1'b1;
          st_next.start_seen = 1'b0;
        end
        // RULE_16 latch contact error
        // RULE_12 error raises output and restart request
        if (c_det)
          st_next.c_err = 1'b1;
        if (r_det)
          st_next.r_err = 1'b1;
        if (c_det || r_det)
        begin
          st_next.rst_req  = 1'b1;
          st_next.up_phase = 1'b0;
        end
      end
      // Previous samples for next cycle
      st_next.udp_q   = udp;
      st_next.ldp_q   = ldp;
      st_next.rd_q    = rd;
      st_next.rst_q   = rst;
      st_next.start_q = drive_start;
      // RULE_15 release blocked while restart required
      // RULE_12 release high when clean
      st_next.rel_o  = rel & ~(st_next.c_err | st_next.r_err) & ~st_next.rst_req;
      // RULE_13 top from upper contact, gated
      st_next.top_o  = rel & ~(st_next.c_err | st_next.r_err) & ~udp;
      // RULE_11 outputs drop while release low
      st_next.up_o   = rel & ~(st_next.c_err | st_next.r_err) & st_next.up_phase;
      // RULE_01 optional summary flag
      st_next.flag_o = cfg_error_flag_enable & (st_next.c_err | st_next.r_err);
    end
  end
  // State register; monitoring starts afresh after reset
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= pcm_mon_s'{init: 1'b1, default: '0};
    else
      st_reg <= st_next;
  end
  assign release_out      = st_reg.rel_o;
  assign top_out          = st_reg.top_o;
  assign upstroke_out     = st_reg.up_o;
  assign restart_required = st_reg.rst_req;
  assign contact_error    = st_reg.c_err;
  assign ramp_down_error  = st_reg.r_err;
  assign error_flag       = st_reg.flag_o;
endmodule : pcm_monitor

// file: testbench/pcm_monitor_props.sv
`timescale 1ns/100ps
module pcm_monitor_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic upper_dead_point_contact,
  input wire logic lower_dead_point_contact,
  input wire logic release_in,
  input wire logic cfg_restart_enable,
  input wire logic cfg_error_flag_enable,
  input wire logic release_out,
  input wire logic top_out,
  input wire logic upstroke_out,
  input wire logic restart_required,
  input wire logic contact_error,
  input wire logic ramp_down_error,
  input wire logic error_flag
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Pin filter lag is at least three edges, so depth 3 sees the settled pin
  AST_ERR_FLAG: assert property (
    (cfg_error_flag_enable && (contact_error || ramp_down_error))[*2] |-> error_flag)
    else $error("error flag not raised");
  AST_FLAG_OFF: assert property (!cfg_error_flag_enable |-> !error_flag)
    else $error("error flag raised while disabled");
  AST_ERR_GATE: assert property (
    (contact_error || ramp_down_error) |-> !release_out && !top_out && !upstroke_out)
    else $error("outputs active during error");
  AST_RR_BLOCK: assert property (restart_required |-> !release_out)
    else $error("release high while restart pending");
  AST_RR_CAUSE: assert property (
    $rose(restart_required) |-> contact_error || ramp_down_error)
    else $error("restart pending without error");
  AST_ERR_CLR: assert property (
    $fell(contact_error) || $fell(ramp_down_error) |-> $fell(restart_required))
    else $error("errors cleared apart from restart flag");
  AST_NO_RST: assert property (
    !cfg_restart_enable && restart_required |=> restart_required)
    else $error("error cleared with restart disabled");
  AST_TOP_SRC: assert property (
    $rose(top_out) |-> !$past(upper_dead_point_contact, 3) && $past(release_in, 3))
    else $error("top rose without cause");
  AST_UP_SRC: assert property (
    $rose(upstroke_out) |-> $past(lower_dead_point_contact, 3)
      && $past(upper_dead_point_contact, 3))
    else $error("upstroke rose without lower edge");
  AST_REL_OFF: assert property (
    !release_in [*8] |-> !release_out && !top_out && !upstroke_out)
    else $error("outputs active with release input low");
endmodule : pcm_monitor_props
bind pcm_monitor pcm_monitor_props u_pcm_monitor_props (.ref_clk(ref_clk), .resetn(resetn),
  .upper_dead_point_contact(upper_dead_point_contact), .release_in(release_in),
  .lower_dead_point_contact(lower_dead_point_contact), .top_out(top_out),
  .cfg_restart_enable(cfg_restart_enable), .cfg_error_flag_enable(cfg_error_flag_enable),
  .release_out(release_out), .upstroke_out(upstroke_out), .error_flag(error_flag),
  .restart_required(restart_required), .contact_error(contact_error),
  .ramp_down_error(ramp_down_error));

// file: testbench/pcm_press_model.sv
`timescale 1ns/100ps
module pcm_press_model (
  input  wire logic ref_clk,
  output logic      upper_dead_point_contact,
  output logic      lower_dead_point_contact,
  output logic      ramp_down_contact,
  output logic      drive_start
);
  // Rest position: top area, ramp-down contact closed
  initial
  begin
    upper_dead_point_contact = 1'b0;
    lower_dead_point_contact = 1'b0;
    ramp_down_contact        = 1'b1;
    drive_start              = 1'b0;
  end
  // Contacts move after an edge, then stand long enough to pass the filter
  task automatic step(input logic u, input logic l, input logic r);
    @(posedge ref_clk);
    upper_dead_point_contact <= u;
    lower_dead_point_contact <= l;
    ramp_down_contact        <= r;
    repeat (10) @(posedge ref_clk);
  endtask : step
  task automatic cycle(input logic st, input int n);
    step(1'b1, 1'b0, 1'b1);
    drive_start <= st;
    step(1'b1, 1'b0, 1'b0);
    repeat (n)
    begin
      step(1'b1, 1'b1, 1'b0);
      step(1'b1, 1'b0, 1'b0);
    end
    step(1'b1, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b1);
    drive_start <= 1'b0;
  endtask : cycle
endmodule : pcm_press_model

// file: testbench/test_pcm_monitor.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_pcm_monitor;
  logic ref_clk = 1'b0;
  logic resetn, restart_in, release_in, cfg_restart_enable, cfg_lower_multi;
  logic cfg_restart_long, cfg_error_flag_enable, cfg_ramp_down_enable, up_q;
  logic udp, ldp, rd, ds, release_out, top_out, upstroke_out;
  logic restart_required, contact_error, ramp_down_error, error_flag;
  int   err_total = 0, n_compared = 0, up_rises = 0, b;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  pcm_press_model u_pcm_press_model (.ref_clk(ref_clk), .upper_dead_point_contact(udp),
    .lower_dead_point_contact(ldp), .ramp_down_contact(rd), .drive_start(ds));
  // Short restart limits keep the run brief
  pcm_monitor #(.RST_MIN_SHORT_CYC(32'h0A), .RST_MIN_LONG_CYC(32'h23), .RST_MAX_CYC(32'h12C))
    u_pcm_monitor (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
    .upper_dead_point_contact(udp), .lower_dead_point_contact(ldp), .ramp_down_contact(rd),
    .restart_in(restart_in), .release_in(release_in), .drive_start(ds),
    .cfg_restart_enable(cfg_restart_enable), .cfg_lower_multi(cfg_lower_multi),
    .cfg_restart_long(cfg_restart_long), .cfg_error_flag_enable(cfg_error_flag_enable),
    .cfg_ramp_down_enable(cfg_ramp_down_enable), .release_out(release_out), .top_out(top_out),
    .upstroke_out(upstroke_out), .restart_required(restart_required),
    .contact_error(contact_error), .ramp_down_error(ramp_down_error),
    .error_flag(error_flag));
  // Upstroke rises counted, so a cycle's count is a difference
  always @(posedge ref_clk)
  begin
    up_q <= upstroke_out;
    if (upstroke_out === 1'b1 && up_q !== 1'b1)
      up_rises <= up_rises + 1;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : waitc
  // Restart pulse of n cycles, then time for the filter and init cycle
  task automatic pulse(input int n);
    restart_in <= 1'b1;
    waitc(n);
    restart_in <= 1'b0;
    waitc(12);
  endtask : pulse
  task automatic expect_out(input string nm, input logic rel, input logic ce, input logic rde);
    `CHK({nm, " release"}, rel, release_out)
    `CHK({nm, " top"}, rel, top_out)
    `CHK({nm, " contact"}, ce, contact_error)
    `CHK({nm, " ramp"}, rde, ramp_down_error)
    `CHK({nm, " restart"}, ce | rde, restart_required)
    $display("test %s done", nm);
  endtask : expect_out
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // Hang guard, far beyond the expected run
  initial
  begin
    #300000;
    err_total++;
    summarize();
  end
  initial
  begin
    {resetn, restart_in, cfg_lower_multi, cfg_restart_long} = 4'h0;
    {release_in, cfg_restart_enable, cfg_error_flag_enable, cfg_ramp_down_enable} = 4'hF;
    waitc(8);
    resetn <= 1'b1;
    waitc(12);
    expect_out("idle", 1'b1, 1'b0, 1'b0);
    b = up_rises;
    u_pcm_press_model.cycle(1'b1, 1);
    `CHK("single upstroke", 1, up_rises - b)
    expect_out("cycle", 1'b1, 1'b0, 1'b0);
    u_pcm_press_model.cycle(1'b0, 1);
    expect_out("ramp", 1'b0, 1'b0, 1'b1);
    `CHK("flag", 1'b1, error_flag)
    release_in <= 1'b0;
    waitc(12);
    expect_out("release low", 1'b0, 1'b0, 1'b1);
    release_in <= 1'b1;
    waitc(12);
    pulse(5);
    pulse(400);
    expect_out("bad pulses", 1'b0, 1'b0, 1'b1);
    pulse(20);
    expect_out("restart", 1'b1, 1'b0, 1'b0);
    cfg_restart_long <= 1'b1;
    u_pcm_press_model.step(1'b0, 1'b1, 1'b1);
    u_pcm_press_model.step(1'b0, 1'b0, 1'b1);
    pulse(20);
    expect_out("contact", 1'b0, 1'b1, 1'b0);
    pulse(40);
    expect_out("long restart", 1'b1, 1'b0, 1'b0);
    cfg_lower_multi <= 1'b1;
    b = up_rises;
    u_pcm_press_model.cycle(1'b1, 2);
    `CHK("double lower", 1, up_rises - b)
    b = up_rises;
    u_pcm_press_model.cycle(1'b1, 0);
    `CHK("no lower", 0, up_rises - b)
    expect_out("multi", 1'b1, 1'b0, 1'b0);
    // Ramp-down checks off: leaving with drive start low is no error
    cfg_ramp_down_enable <= 1'b0;
    u_pcm_press_model.cycle(1'b0, 1);
    expect_out("ramp off", 1'b1, 1'b0, 1'b0);
    cfg_restart_enable <= 1'b0;
    cfg_error_flag_enable <= 1'b0;
    u_pcm_press_model.step(1'b0, 1'b1, 1'b1);
    u_pcm_press_model.step(1'b0, 1'b0, 1'b1);
    // Long enough to count if the input were enabled
    pulse(40);
    expect_out("no restart", 1'b0, 1'b1, 1'b0);
    `CHK("flag off", 1'b0, error_flag)
    // Press parked in the lower area across the program restart
    u_pcm_press_model.step(1'b1, 1'b1, 1'b0);
    resetn <= 1'b0;
    waitc(8);
    resetn <= 1'b1;
    waitc(12);
    b = up_rises;
    u_pcm_press_model.step(1'b1, 1'b0, 1'b0);
    u_pcm_press_model.step(1'b1, 1'b1, 1'b0);
    u_pcm_press_model.step(1'b0, 1'b0, 1'b1);
    `CHK("lower at start", 0, up_rises - b)
    expect_out("program restart", 1'b1, 1'b0, 1'b0);
    summarize();
  end
endmodule : test_pcm_monitor
